// ===== src/tecnt_top.sv
// t1/e1 receive error counters with axi4-lite register access
//
// What this block does
// - t1 uncoded: count bipolar violations, plus 16-zero runs when selected.
// - t1 b8zs: skip valid codewords; count 8-zero runs when selected.
// - t1 line violation counting never stops on receive sync loss.
// - e1 line counter: bipolar violations when select is 0, code violations when 1.
// - e1 bipolar mode: same-polarity marks count; hdb3 codewords excluded.
// - e1 code violation: two successive violations of one polarity.
// - e1 line counter ignores sync loss and saturates at 65535.
// - line count high byte at 42h, low byte at 43h.
// - t1 esf: path counter counts crc6 errors.
// - t1 d4: path counter counts ft errors, and fs errors when enabled.
// - t1 path counter halts while receive sync is lost.
// - e1 path counter counts crc4 errors, halts on fas or crc4 loss only.
// - path count high byte at 44h, low byte at 45h.
// - t1 multiframe mode counts out-of-sync multiframes, only while receive sync is lost.
// - t1 f-bit mode counts ft or fps errors, halts on sync loss.
// - e1 counts fas word errors, halts while receive sync lost.
// - e1 ignores fas errors during fas, cas or crc4 searching.
// - frames count high byte at 46h, low byte at 47h.
// - auto update each second, or 333/500 frames when fast.
// - manual trigger rising edge updates next clock; software waits before reading.
// - every counter saturates at its maximum value.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tecnt_top (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// line decoder strobes
	input wire logic rx_bit_valid,
	input wire logic rx_bit_mark,
	input wire logic bpv_strobe,
	input wire logic bpv_positive,
	input wire logic codeword_strobe,
	// framer strobes
	input wire logic frame_tick,
	input wire logic multiframe_tick,
	input wire logic crc_error_strobe,
	input wire logic ft_error_strobe,
	input wire logic fs_error_strobe,
	input wire logic fps_error_strobe,
	input wire logic fas_error_strobe,
	// framer sync state
	input wire logic receive_sync_lost_flag,
	input wire logic fas_sync_lost,
	input wire logic crc4_sync_lost,
	input wire logic frame_search_active,
	// update indication
	output logic counts_updated
);
	tecnt_pkg::tecnt_chan_e wr_state_q;
	tecnt_pkg::tecnt_chan_e rd_state_q;
	logic [7:0] error_counter_config_q;
	logic [7:0] line_mode_q;
	logic [1:0] bresp_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic wr_fire;
	logic rd_fire;
	logic wr_lane0;
	logic e1_mode;
	logic esf_mode;
	logic b8zs_on;
	logic hdb3_on;
	logic [4:0] zero_run_q;
	logic [4:0] zero_limit;
	logic excess_zero_event;
	logic last_bpv_pos_q;
	logic bpv_seen_q;
	logic code_viol_event;
	logic t1_bpv_counted;
	logic e1_bpv_counted;
	logic lvc_inc;
	logic pvc_inc;
	logic fos_inc;
	logic update;
	logic [15:0] lvc_snap;
	logic [15:0] pvc_snap;
	logic [15:0] fos_snap;

	assign e1_mode = line_mode_q[tecnt_pkg::MODE_E1];
	assign esf_mode = line_mode_q[tecnt_pkg::MODE_ESF];
	assign b8zs_on = line_mode_q[tecnt_pkg::MODE_B8ZS];
	assign hdb3_on = line_mode_q[tecnt_pkg::MODE_HDB3];

	// excessive zero detection; a long run is counted once, when it reaches the limit
	assign zero_limit = b8zs_on ? tecnt_pkg::ZERO_RUN_B8ZS : tecnt_pkg::ZERO_RUN_T1;
	assign excess_zero_event = rx_bit_valid && !rx_bit_mark
		&& (zero_run_q == zero_limit - 5'h01);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			zero_run_q <= tecnt_pkg::ZERO_RUN_RESET;
		else if (ce && rx_bit_valid)
		begin
			if (rx_bit_mark)
				zero_run_q <= tecnt_pkg::ZERO_RUN_RESET;
			else if (zero_run_q < zero_limit)
				zero_run_q <= zero_run_q + 5'h01;
		end
	end

	// polarity of the previous violation, raw, so hdb3 substitutions still take part
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			last_bpv_pos_q <= 1'b0;
			bpv_seen_q <= 1'b0;
		end
		else if (ce && bpv_strobe)
		begin
			last_bpv_pos_q <= bpv_positive;
			bpv_seen_q <= 1'b1;
		end
	end

	assign code_viol_event = bpv_strobe && bpv_seen_q && (bpv_positive == last_bpv_pos_q);
	assign t1_bpv_counted = bpv_strobe && !(b8zs_on && codeword_strobe);
	assign e1_bpv_counted = bpv_strobe && !(hdb3_on && codeword_strobe);

	// line violations are never gated by sync state
	always_comb
	begin
		if (e1_mode)
		begin
			if (error_counter_config_q[tecnt_pkg::CFG_CODE_VIOL])
				lvc_inc = code_viol_event;
			else
				lvc_inc = e1_bpv_counted;
		end
		else
		begin
			lvc_inc = t1_bpv_counted
				|| (error_counter_config_q[tecnt_pkg::CFG_EXCESS_ZERO] && excess_zero_event);
		end
	end

	// path violations
	always_comb
	begin
		if (e1_mode)
			pvc_inc = crc_error_strobe && !fas_sync_lost && !crc4_sync_lost;
		else if (receive_sync_lost_flag)
			pvc_inc = 1'b0;
		else if (esf_mode)
			pvc_inc = crc_error_strobe;
		else
			pvc_inc = ft_error_strobe
				|| (error_counter_config_q[tecnt_pkg::CFG_FS_REPORT] && fs_error_strobe);
	end

	// frames out of sync
	always_comb
	begin
		if (e1_mode)
			fos_inc = fas_error_strobe && !receive_sync_lost_flag && !frame_search_active;
		else if (error_counter_config_q[tecnt_pkg::CFG_MF_OR_FBIT])
			fos_inc = multiframe_tick && receive_sync_lost_flag;
		else if (receive_sync_lost_flag)
			fos_inc = 1'b0;
		else
			fos_inc = esf_mode ? fps_error_strobe : ft_error_strobe;
	end

	tecnt_update_ctrl u_update (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.e1_mode(e1_mode),
		.fast_update(error_counter_config_q[tecnt_pkg::CFG_FAST_UPDATE]),
		.manual_mode(error_counter_config_q[tecnt_pkg::CFG_ACCUM_MODE]),
		.manual_trigger(error_counter_config_q[tecnt_pkg::CFG_MANUAL_TRIG]),
		.frame_tick(frame_tick),
		.update_q(update)
	);

	assign counts_updated = update;

	tecnt_sat_counter u_lvc (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.inc(lvc_inc),
		.update(update),
		.snapshot_q(lvc_snap)
	);

	tecnt_sat_counter u_pvc (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.inc(pvc_inc),
		.update(update),
		.snapshot_q(pvc_snap)
	);

	tecnt_sat_counter u_fos (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.inc(fos_inc),
		.update(update),
		.snapshot_q(fos_snap)
	);

	// write channel: address and data are taken together in one cycle
	assign wr_idx = s_axi_awaddr[tecnt_pkg::IDX_LSB +: tecnt_pkg::IDX_W];
	assign wr_fire = ce && (wr_state_q == tecnt_pkg::CH_IDLE) && s_axi_awvalid && s_axi_wvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign wr_lane0 = s_axi_wstrb[0];
	assign s_axi_bvalid = (wr_state_q == tecnt_pkg::CH_RESP);
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wr_state_q <= tecnt_pkg::CH_IDLE;
		else if (ce)
		begin
			case (wr_state_q)
				tecnt_pkg::CH_IDLE:
					if (wr_fire)
						wr_state_q <= tecnt_pkg::CH_RESP;
				tecnt_pkg::CH_RESP:
					if (s_axi_bready)
						wr_state_q <= tecnt_pkg::CH_IDLE;
				default:
					wr_state_q <= tecnt_pkg::CH_IDLE;
			endcase
		end
	end

	// count registers accept writes without effect; unmapped addresses error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp_q <= tecnt_pkg::RESP_OKAY;
		else if (wr_fire)
		begin
			if (s_axi_awaddr[1:0] == 2'h0 && wr_idx >= tecnt_pkg::IDX_LINE_MODE
				&& wr_idx <= tecnt_pkg::IDX_FOS_LOW)
				bresp_q <= tecnt_pkg::RESP_OKAY;
			else
				bresp_q <= tecnt_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			error_counter_config_q <= tecnt_pkg::CFG_RESET;
		else if (wr_fire && wr_lane0 && s_axi_awaddr[1:0] == 2'h0
			&& wr_idx == tecnt_pkg::IDX_ERR_CFG)
			error_counter_config_q <= s_axi_wdata[7:0] & tecnt_pkg::CFG_WR_MASK;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			line_mode_q <= tecnt_pkg::MODE_RESET;
		else if (wr_fire && wr_lane0 && s_axi_awaddr[1:0] == 2'h0
			&& wr_idx == tecnt_pkg::IDX_LINE_MODE)
			line_mode_q <= s_axi_wdata[7:0] & tecnt_pkg::MODE_WR_MASK;
	end

	// read channel: one cycle from address to data
	assign rd_idx = s_axi_araddr[tecnt_pkg::IDX_LSB +: tecnt_pkg::IDX_W];
	assign rd_fire = ce && (rd_state_q == tecnt_pkg::CH_IDLE) && s_axi_arvalid;
	assign s_axi_arready = rd_fire;
	assign s_axi_rvalid = (rd_state_q == tecnt_pkg::CH_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_state_q <= tecnt_pkg::CH_IDLE;
		else if (ce)
		begin
			case (rd_state_q)
				tecnt_pkg::CH_IDLE:
					if (rd_fire)
						rd_state_q <= tecnt_pkg::CH_RESP;
				tecnt_pkg::CH_RESP:
					if (s_axi_rready)
						rd_state_q <= tecnt_pkg::CH_IDLE;
				default:
					rd_state_q <= tecnt_pkg::CH_IDLE;
			endcase
		end
	end

	// reads only look at snapshots, the running counters are left alone
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_q <= 32'h00000000;
			rresp_q <= tecnt_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rresp_q <= tecnt_pkg::RESP_OKAY;
			rdata_q <= 32'h00000000;
			if (s_axi_araddr[1:0] != 2'h0)
				rresp_q <= tecnt_pkg::RESP_SLVERR;
			else
			begin
				case (rd_idx)
					tecnt_pkg::IDX_LINE_MODE:
						rdata_q[7:0] <= line_mode_q;
					tecnt_pkg::IDX_ERR_CFG:
						rdata_q[7:0] <= error_counter_config_q;
					tecnt_pkg::IDX_LVC_HIGH:
						rdata_q[7:0] <= lvc_snap[15:8];
					tecnt_pkg::IDX_LVC_LOW:
						rdata_q[7:0] <= lvc_snap[7:0];
					tecnt_pkg::IDX_PVC_HIGH:
						rdata_q[7:0] <= pvc_snap[15:8];
					tecnt_pkg::IDX_PVC_LOW:
						rdata_q[7:0] <= pvc_snap[7:0];
					tecnt_pkg::IDX_FOS_HIGH:
						rdata_q[7:0] <= fos_snap[15:8];
					tecnt_pkg::IDX_FOS_LOW:
						rdata_q[7:0] <= fos_snap[7:0];
					default:
						rresp_q <= tecnt_pkg::RESP_SLVERR;
				endcase
			end
		end
	end
endmodule

// ===== pkg/tecnt_pkg.sv
// shared constants for the t1/e1 receive error counters
package tecnt_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LINE_MODE = 8'h40;
	localparam logic [7:0] IDX_ERR_CFG = 8'h41;
	localparam logic [7:0] IDX_LVC_HIGH = 8'h42;
	localparam logic [7:0] IDX_LVC_LOW = 8'h43;
	localparam logic [7:0] IDX_PVC_HIGH = 8'h44;
	localparam logic [7:0] IDX_PVC_LOW = 8'h45;
	localparam logic [7:0] IDX_FOS_HIGH = 8'h46;
	localparam logic [7:0] IDX_FOS_LOW = 8'h47;
	localparam int ADDR_W = 12;
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 8;
	// error counter config fields
	localparam int CFG_EXCESS_ZERO = 0;
	localparam int CFG_MF_OR_FBIT = 1;
	localparam int CFG_FS_REPORT = 2;
	localparam int CFG_CODE_VIOL = 3;
	localparam int CFG_ACCUM_MODE = 4;
	localparam int CFG_FAST_UPDATE = 5;
	localparam int CFG_MANUAL_TRIG = 6;
	localparam logic [7:0] CFG_WR_MASK = 8'h7f;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// line mode fields
	localparam int MODE_E1 = 0;
	localparam int MODE_ESF = 1;
	localparam int MODE_B8ZS = 2;
	localparam int MODE_HDB3 = 3;
	localparam logic [7:0] MODE_WR_MASK = 8'h0f;
	localparam logic [7:0] MODE_RESET = 8'h00;
	// counting
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [4:0] ZERO_RUN_T1 = 5'h10;
	localparam logic [4:0] ZERO_RUN_B8ZS = 5'h08;
	localparam logic [4:0] ZERO_RUN_RESET = 5'h00;
	localparam logic [13:0] FRAMES_PER_SECOND = 14'h1f40;
	localparam logic [13:0] FRAMES_FAST_T1 = 14'h014d;
	localparam logic [13:0] FRAMES_FAST_E1 = 14'h01f4;
	localparam logic [13:0] FRAMES_RESET = 14'h0000;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CH_IDLE = 2'b01,
		CH_RESP = 2'b10
	} tecnt_chan_e;
endpackage

// ===== src/tecnt_sat_counter.sv
// saturating 16-bit event counter with snapshot register
`timescale 1ns/1ps
module tecnt_sat_counter (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// control
	input wire logic inc,
	input wire logic update,
	// snapshot
	output logic [15:0] snapshot_q
);
	logic [15:0] count_q;

	// an event in the update cycle starts the new interval, so none is lost
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_q <= tecnt_pkg::CNT_RESET;
		else if (ce)
		begin
			if (update)
				count_q <= inc ? 16'h0001 : tecnt_pkg::CNT_RESET;
			else if (inc && count_q != tecnt_pkg::CNT_MAX)
				count_q <= count_q + 16'h0001;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			snapshot_q <= tecnt_pkg::CNT_RESET;
		else if (ce && update)
			snapshot_q <= count_q;
	end
endmodule

// ===== src/tecnt_update_ctrl.sv
// periodic or manual update strobe for the error counters
`timescale 1ns/1ps
module tecnt_update_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// configuration
	input wire logic e1_mode,
	input wire logic fast_update,
	input wire logic manual_mode,
	input wire logic manual_trigger,
	// framer timing
	input wire logic frame_tick,
	// result
	output logic update_q
);
	logic [13:0] frames_q;
	logic [13:0] limit;
	logic trig_prev_q;
	logic auto_hit;

	always_comb
	begin
		if (!fast_update)
			limit = tecnt_pkg::FRAMES_PER_SECOND;
		else if (e1_mode)
			limit = tecnt_pkg::FRAMES_FAST_E1;
		else
			limit = tecnt_pkg::FRAMES_FAST_T1;
	end

	assign auto_hit = frame_tick && (frames_q >= limit - 14'h0001);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			frames_q <= tecnt_pkg::FRAMES_RESET;
		else if (ce && frame_tick)
			frames_q <= auto_hit ? tecnt_pkg::FRAMES_RESET : frames_q + 14'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			trig_prev_q <= 1'b0;
		else if (ce)
			trig_prev_q <= manual_trigger;
	end

	// manual rising edge gives the update on the following clock
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			update_q <= 1'b0;
		else if (ce)
			update_q <= manual_mode ? (manual_trigger && !trig_prev_q) : auto_hit;
	end
endmodule

// ===== verif/tecnt_line_model.sv
// far-side model: line decoder and framer strobes plus sync levels
`timescale 1ns/1ps
module tecnt_line_model (
	// clock
	input wire logic aclk,
	// strobes and levels
	output logic [9:0] ev,
	output logic [3:0] lvl,
	output logic bv,
	output logic bm
);
	initial
	begin
		ev = '0;
		lvl = '0;
		bv = 1'b0;
		bm = 1'b1;
	end
	task set(input logic [3:0] l);
		lvl <= l;
		@(posedge aclk);
	endtask
	// polarity is flipped when idle so a stale value never looks like a real one
	task pulse(input logic [9:0] s);
		ev <= s;
		@(posedge aclk);
		ev <= {8'h0, ~s[1], 1'b0};
		@(posedge aclk);
	endtask
	// a strobe pattern held for n cycles, long enough to drive a counter into saturation
	task hold(input logic [9:0] s, input int n);
		ev <= s;
		repeat (n) @(posedge aclk);
		ev <= '0;
		@(posedge aclk);
	endtask
	// a run of n zeros closed by a mark
	task zeros(input int n);
		bv <= 1'b1;
		bm <= 1'b0;
		repeat (n) @(posedge aclk);
		bm <= 1'b1;
		@(posedge aclk);
		bv <= 1'b0;
		bm <= 1'b0;
		@(posedge aclk);
	endtask
endmodule

// ===== verif/tecnt_top_properties.sv
// bus and update assertions for the error counter block
`timescale 1ns/1ps
module tecnt_top_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// write side
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read side
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// update
	input wire logic counts_updated
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_AW_PAIR: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
		else $error("write taken without both channels");
	AST_B_NEXT: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("no write response after take");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data after take");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	AST_R_BYTE: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	AST_R_ERRZERO: assert property (s_axi_rvalid && s_axi_rresp == tecnt_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read returned data");
	AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_UPD_ONE: assert property (counts_updated && ce |=> !counts_updated)
		else $error("update pulse longer than one cycle");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == tecnt_pkg::RESP_SLVERR);
	cover property (counts_updated);
endmodule
bind tecnt_top tecnt_top_chk u_chk (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counts_updated);

// ===== verif/tecnt_top_test.sv
// self-checking bench for the error counter block
`timescale 1ns/1ps
module tecnt_top_test;
	localparam logic [11:0] MODE = {2'h0, tecnt_pkg::IDX_LINE_MODE, 2'h0};
	localparam logic [11:0] CFG = {2'h0, tecnt_pkg::IDX_ERR_CFG, 2'h0};
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, upd, bv, bm;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [9:0] ev;
	logic [3:0] lvl;
	logic [3:0] ws;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int n_errors, cmp_count, n_upd, n;
	tecnt_line_model fw (.aclk, .ev, .lvl, .bv, .bm);
	tecnt_top uut (.aclk, .aresetn, .ce, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_bit_valid(bv), .rx_bit_mark(bm), .bpv_strobe(ev[0]), .bpv_positive(ev[1]),
		.codeword_strobe(ev[2]), .frame_tick(ev[3]), .multiframe_tick(ev[4]),
		.crc_error_strobe(ev[5]), .ft_error_strobe(ev[6]), .fs_error_strobe(ev[7]),
		.fps_error_strobe(ev[8]), .fas_error_strobe(ev[9]), .receive_sync_lost_flag(lvl[0]),
		.fas_sync_lost(lvl[1]), .crc4_sync_lost(lvl[2]), .frame_search_active(lvl[3]),
		.counts_updated(upd));
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input logic [33:0] e, input logic [33:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		bq.push_back(r);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
		rq.push_back({r, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// counts in high/low byte order, line then path then frames
	task rc(input logic [15:0] l, input logic [15:0] p, input logic [15:0] f);
		logic [15:0] v[3];
		v = '{l, p, f};
		for (int k = 0; k < 6; k++)
			rd(ad(tecnt_pkg::IDX_LVC_HIGH + 8'(k)), k[0] ? v[k/2][7:0] : v[k/2][15:8], 2'h0);
	endtask
	// manual trigger: bit 6 raised then dropped, snapshot lands two cycles after
	task up(input logic [7:0] c);
		wr(CFG, c | 8'h40, 2'h0);
		wr(CFG, c, 2'h0);
		repeat (2) @(posedge aclk);
	endtask
	always @(posedge aclk)
	begin
		if (rvalid === 1'b1 && rready)
			chk("read", rq.pop_front(), {rresp, rdata});
		if (bvalid === 1'b1 && bready)
			chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
		if (upd === 1'b1)
			n_upd++;
	end
	// whole run is about 70000 cycles, mostly the saturation hold; this leaves some margin
	initial
	begin
		#400000;
		n_errors++;
		stop_test;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		ce = 1'b1;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		ws = 4'hf;
		n = $urandom(7);
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(0, 0, 0);
		n = 1 + $urandom % 4;
		wr(CFG, 8'h11, 2'h0);
		fw.set(4'h1);
		repeat (n) fw.pulse(10'h003);
		fw.pulse(10'h040);
		fw.set(4'h0);
		fw.zeros(17);
		repeat (2) fw.pulse(10'h040);
		fw.pulse(10'h080);
		fw.pulse(10'h100);
		fw.pulse(10'h020);
		up(8'h11);
		rc(16'(n + 1), 2, 2);
		wr(MODE, 8'h06, 2'h0);
		wr(CFG, 8'h17, 2'h0);
		fw.pulse(10'h007);
		fw.zeros(8);
		fw.pulse(10'h020);
		fw.pulse(10'h040);
		fw.set(4'h1);
		repeat (3) fw.pulse(10'h010);
		fw.pulse(10'h020);
		up(8'h17);
		rc(1, 1, 3);
		wr(MODE, 8'h09, 2'h0);
		wr(CFG, 8'h18, 2'h0);
		fw.pulse(10'h001);
		fw.pulse(10'h003);
		fw.pulse(10'h003);
		fw.pulse(10'h001);
		fw.pulse(10'h020);
		fw.set(4'h2);
		fw.pulse(10'h020);
		fw.set(4'h4);
		fw.pulse(10'h020);
		fw.set(4'h8);
		fw.pulse(10'h200);
		fw.set(4'h1);
		fw.pulse(10'h200);
		fw.set(4'h0);
		fw.pulse(10'h200);
		up(8'h18);
		rc(1, 1, 1);
		wr(ad(tecnt_pkg::IDX_LVC_LOW), 8'h55, 2'h0);
		rd(ad(tecnt_pkg::IDX_LVC_LOW), 8'h01, 2'h0);
		wr(12'h120, 8'h00, tecnt_pkg::RESP_SLVERR);
		rd(12'h101, 8'h00, tecnt_pkg::RESP_SLVERR);
		ws <= 4'he;
		wr(CFG, 8'h00, 2'h0);
		ws <= 4'hf;
		rd(CFG, 8'h18, 2'h0);
		wr(MODE, 8'h00, 2'h0);
		wr(CFG, 8'h20, 2'h0);
		// a violation while the clock enable is low must leave no trace
		ce <= 1'b0;
		fw.pulse(10'h003);
		ce <= 1'b1;
		fw.pulse(10'h003);
		repeat (332) fw.pulse(10'h008);
		chk("updates", 34'd3, 34'(n_upd));
		fw.pulse(10'h008);
		repeat (2) @(posedge aclk);
		chk("updates", 34'd4, 34'(n_upd));
		rc(1, 0, 0);
		wr(MODE, 8'h01, 2'h0);
		wr(CFG, 8'h10, 2'h0);
		fw.hold(10'h001, 65540);
		up(8'h10);
		rc(16'hffff, 0, 0);
		// mid-run reset clears snapshots and configuration
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(0, 0, 0);
		rd(CFG, 8'h00, 2'h0);
		stop_test;
	end
endmodule
